/* core/radio_status_pkg.sv */
// constants for the radio status readback register group
package radio_status_pkg;

    // ********************************************************
    // register offsets
    // ********************************************************
    localparam logic [5:0] OFS_PACKET_AND_PIN_STATUS = 6'h38;
    localparam logic [5:0] OFS_LOOP_CAL_DAC_READBACK = 6'h39;
    localparam logic [5:0] OFS_TRANSMIT_BUFFER_LEVEL = 6'h3a;
    localparam logic [5:0] OFS_RECEIVE_BUFFER_LEVEL = 6'h3b;
    localparam logic [5:0] OFS_SLOW_OSC_CAL_RESULT_HIGH = 6'h3c;
    localparam logic [5:0] OFS_SLOW_OSC_CAL_RESULT_LOW = 6'h3d;

    // ********************************************************
    // field positions and widths
    // ********************************************************
    localparam int BIT_CHECKSUM_OK = 7;
    localparam int BIT_CARRIER_SENSE = 6;
    localparam int BIT_PREAMBLE_QUALITY_MET = 5;
    localparam int BIT_CHANNEL_CLEAR = 4;
    localparam int BIT_FRAME_START = 3;
    localparam int BIT_PIN2_LEVEL = 2;
    localparam int BIT_PIN0_LEVEL = 0;
    localparam int BIT_BUFFER_FLAG = 7;
    localparam int COUNT_W = 7;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 6;
    localparam int STATE_W = 5;

    // ********************************************************
    // radio control state codes
    // ********************************************************
    localparam logic [4:0] ST_IDLE = 5'h01;
    localparam logic [4:0] ST_RX = 5'h0d;
    localparam logic [4:0] ST_RX_END = 5'h0e;
    localparam logic [4:0] ST_RX_RST = 5'h0f;
    localparam logic [4:0] ST_RX_OVERRUN = 5'h11;
    localparam logic [4:0] ST_TX = 5'h13;
    localparam logic [4:0] ST_TX_END = 5'h14;

    // ********************************************************
    // reset values
    // ********************************************************
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [6:0] RST_COUNT = 7'h00;
    localparam logic [4:0] RST_STATE = 5'h00;

endpackage

/* core/radio_status_readback.sv */
// read-only packet, pin, buffer and calibration status registers
// Behaviour
// - checksum ok set on match, cleared entering rx
// - carrier sense bit, cleared in idle
// - preamble quality held outside rx
// - preamble quality cleared when indicator below threshold
// - frame start set on sync, cleared at end
// - frame start cleared on drop or overrun
// - frame start reads zero while transmitting
// - bit 2 shows pin 2 before inversion
// - bit 0 shows pin 0 before inversion
// - transmit level: underrun bit 7, count 6:0
// - receive level: overrun bit 7, count 6:0
// - loop calibration dac readable, eight bits
// - oscillator cal results in bits 6:0
`timescale 1ns/1ns
module radio_status_readback (
    input wire logic i_clk_sys, // 25 MHz system clock
    input wire logic i_reset_n, // async reset, active low
    input wire logic i_rd_en, // register read strobe
    input wire logic [5:0] i_rd_addr, // register read address
    input wire logic i_wr_en, // register write strobe, only blocks a read
    input wire logic [4:0] i_radio_control_state, // control state code
    input wire logic i_checksum_done, // checksum compared, pulse
    input wire logic i_checksum_match, // checksum result
    input wire logic i_carrier_sense, // carrier sense level
    input wire logic [7:0] i_preamble_quality_indicator, // measured
    input wire logic [7:0] i_preamble_quality_threshold, // programmed
    input wire logic i_channel_clear_flag, // channel assessed clear
    input wire logic i_sync_found, // sync word received, pulse
    input wire logic i_packet_end, // packet finished, pulse
    input wire logic i_packet_dropped, // filtered out, pulse
    input wire logic i_output_pin2_level, // pin 2 before inversion
    input wire logic i_output_pin0_level, // pin 0 before inversion
    input wire logic [7:0] i_loop_cal_dac, // calibration dac setting
    input wire logic i_transmit_buffer_underrun, // tx underrun flag
    input wire logic [6:0] i_transmit_byte_count, // tx bytes held
    input wire logic i_receive_buffer_overrun, // rx overrun flag
    input wire logic [6:0] i_receive_byte_count, // rx bytes held
    input wire logic i_osc_cal_done, // oscillator cal finished, pulse
    input wire logic [6:0] i_osc_cal_high, // cal result, high part
    input wire logic [6:0] i_osc_cal_low, // cal result, low part
    output logic o_rd_valid, // read data valid, pulse
    output logic [7:0] o_rd_data // read data
);

    // ********************************************************
    // helpers
    // ********************************************************
    function automatic logic is_state(input logic [4:0] st,
                                      input logic [4:0] code);
        is_state = (st == code);
    endfunction

    function automatic logic [7:0] flag_count(input logic flag,
                                              input logic [6:0] cnt);
        flag_count = {flag, cnt};
    endfunction

    // ********************************************************
    // state decode
    // ********************************************************
    logic [4:0] prev_state_r;
    wire logic [4:0] st = i_radio_control_state;
    wire logic in_rx = is_state(st, radio_status_pkg::ST_RX);
    wire logic was_rx = is_state(prev_state_r, radio_status_pkg::ST_RX);
    wire logic in_idle = is_state(st, radio_status_pkg::ST_IDLE);
    wire logic in_tx = is_state(st, radio_status_pkg::ST_TX)
                       | is_state(st, radio_status_pkg::ST_TX_END);
    wire logic rx_restart = is_state(st, radio_status_pkg::ST_RX_RST);
    wire logic rx_overrun = is_state(st, radio_status_pkg::ST_RX_OVERRUN);
    wire logic rx_entry = (in_rx & ~was_rx) | rx_restart;
    wire logic rx_family = in_rx
                           | is_state(st, radio_status_pkg::ST_RX_END);

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            prev_state_r <= radio_status_pkg::RST_STATE;
        end else begin
            prev_state_r <= st;
        end
    end

    // ********************************************************
    // packet status flags
    // ********************************************************
    logic checksum_ok_r;
    logic carrier_sense_r;
    logic preamble_quality_met_r;
    logic channel_clear_flag_r;
    logic frame_start_flag_r;
    logic output_pin2_level_r;
    logic output_pin0_level_r;

    wire logic checksum_set = i_checksum_done & i_checksum_match;
    wire logic checksum_clr = rx_entry
                              | (i_checksum_done & ~i_checksum_match);
    // set wins so a match in the entry cycle is not lost
    wire logic checksum_ok_nxt = checksum_set
                                 | (checksum_ok_r & ~checksum_clr);

    wire logic carrier_sense_nxt = i_carrier_sense & ~in_idle;

    wire logic pq_below = i_preamble_quality_indicator
                          < i_preamble_quality_threshold;
    // outside rx the flag only holds; only a weak preamble drops it
    wire logic preamble_quality_met_nxt = pq_below ? 1'b0
        : (in_rx ? 1'b1 : preamble_quality_met_r);

    wire logic frame_start_set = i_sync_found & rx_family;
    wire logic frame_start_clr = i_packet_end | i_packet_dropped
                                 | rx_overrun;
    wire logic frame_start_flag_nxt = frame_start_set
        | (frame_start_flag_r & ~frame_start_clr);

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            checksum_ok_r <= 1'b0;
            carrier_sense_r <= 1'b0;
            preamble_quality_met_r <= 1'b0;
            channel_clear_flag_r <= 1'b0;
            frame_start_flag_r <= 1'b0;
            output_pin2_level_r <= 1'b0;
            output_pin0_level_r <= 1'b0;
        end else begin
            checksum_ok_r <= checksum_ok_nxt;
            carrier_sense_r <= carrier_sense_nxt;
            preamble_quality_met_r <= preamble_quality_met_nxt;
            channel_clear_flag_r <= i_channel_clear_flag;
            frame_start_flag_r <= frame_start_flag_nxt;
            output_pin2_level_r <= i_output_pin2_level;
            output_pin0_level_r <= i_output_pin0_level;
        end
    end

    // ********************************************************
    // calibration results
    // ********************************************************
    logic [6:0] osc_cal_high_r;
    logic [6:0] osc_cal_low_r;

    // latched only at the end of a run, so a read never sees a
    // partial value while the routine is still searching
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            osc_cal_high_r <= radio_status_pkg::RST_COUNT;
            osc_cal_low_r <= radio_status_pkg::RST_COUNT;
        end else if (i_osc_cal_done) begin
            osc_cal_high_r <= i_osc_cal_high;
            osc_cal_low_r <= i_osc_cal_low;
        end
    end

    // ********************************************************
    // read decode
    // ********************************************************
    logic [7:0] packet_and_pin_status;
    always_comb begin
        packet_and_pin_status = radio_status_pkg::RST_BYTE;
        packet_and_pin_status[radio_status_pkg::BIT_CHECKSUM_OK] =
            checksum_ok_r;
        packet_and_pin_status[radio_status_pkg::BIT_CARRIER_SENSE] =
            carrier_sense_r;
        packet_and_pin_status[radio_status_pkg::BIT_PREAMBLE_QUALITY_MET] =
            preamble_quality_met_r;
        packet_and_pin_status[radio_status_pkg::BIT_CHANNEL_CLEAR] =
            channel_clear_flag_r;
        packet_and_pin_status[radio_status_pkg::BIT_FRAME_START] =
            frame_start_flag_r & ~in_tx;
        packet_and_pin_status[radio_status_pkg::BIT_PIN2_LEVEL] =
            output_pin2_level_r;
        packet_and_pin_status[radio_status_pkg::BIT_PIN0_LEVEL] =
            output_pin0_level_r;
    end

    wire logic [7:0] transmit_buffer_level =
        flag_count(i_transmit_buffer_underrun, i_transmit_byte_count);
    wire logic [7:0] receive_buffer_level =
        flag_count(i_receive_buffer_overrun, i_receive_byte_count);
    wire logic [7:0] slow_osc_cal_result_high =
        flag_count(1'b0, osc_cal_high_r);
    wire logic [7:0] slow_osc_cal_result_low =
        flag_count(1'b0, osc_cal_low_r);

    logic [7:0] rd_mux;
    always_comb begin
        case (i_rd_addr)
            radio_status_pkg::OFS_PACKET_AND_PIN_STATUS: begin
                rd_mux = packet_and_pin_status;
            end
            radio_status_pkg::OFS_LOOP_CAL_DAC_READBACK: begin
                rd_mux = i_loop_cal_dac;
            end
            radio_status_pkg::OFS_TRANSMIT_BUFFER_LEVEL: begin
                rd_mux = transmit_buffer_level;
            end
            radio_status_pkg::OFS_RECEIVE_BUFFER_LEVEL: begin
                rd_mux = receive_buffer_level;
            end
            radio_status_pkg::OFS_SLOW_OSC_CAL_RESULT_HIGH: begin
                rd_mux = slow_osc_cal_result_high;
            end
            radio_status_pkg::OFS_SLOW_OSC_CAL_RESULT_LOW: begin
                rd_mux = slow_osc_cal_result_low;
            end
            default: begin
                rd_mux = radio_status_pkg::RST_BYTE;
            end
        endcase
    end

    // writes have no path into any flop here; the strobe is only
    // watched so a write cycle cannot be mistaken for a read
    wire logic rd_take = i_rd_en & ~i_wr_en;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rd_valid <= 1'b0;
            o_rd_data <= radio_status_pkg::RST_BYTE;
        end else begin
            o_rd_valid <= rd_take;
            if (rd_take) begin
                o_rd_data <= rd_mux;
            end
        end
    end

    // ********************************************************
    // checks
    // ********************************************************
    sequence status_read_s;
        rd_take && i_rd_addr == radio_status_pkg::OFS_PACKET_AND_PIN_STATUS;
    endsequence

    sequence tx_status_read_s;
        status_read_s ##0 in_tx;
    endsequence

    checksum_set_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        checksum_set |=> checksum_ok_r)
        else $error("checksum ok not set after match");

    checksum_clr_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        rx_entry && !checksum_set |=> !checksum_ok_r)
        else $error("checksum ok not cleared entering rx");

    carrier_idle_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        in_idle |=> !carrier_sense_r)
        else $error("carrier sense set in idle");

    preamble_hold_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        preamble_quality_met_r && !in_rx && !pq_below
        |=> preamble_quality_met_r)
        else $error("preamble quality dropped outside rx");

    preamble_clear_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        pq_below |=> !preamble_quality_met_r)
        else $error("preamble quality kept below threshold");

    frame_set_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        frame_start_set |=> frame_start_flag_r)
        else $error("frame start not set on sync");

    frame_clear_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_packet_dropped || rx_overrun) && !frame_start_set
        |=> !frame_start_flag_r)
        else $error("frame start kept after drop or overrun");

    frame_tx_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        tx_status_read_s
        |=> o_rd_valid && !o_rd_data[radio_status_pkg::BIT_FRAME_START])
        else $error("frame start read as one in tx");

    // read data leaves one cycle after the take, the pin flops one
    // cycle before it; a take on the first edge out of reset still
    // shows the reset value, so that edge is left out
    pin_levels_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        status_read_s ##0 $past(i_reset_n) |=>
        o_rd_data[radio_status_pkg::BIT_PIN2_LEVEL] ==
        $past(i_output_pin2_level, 2) &&
        o_rd_data[radio_status_pkg::BIT_PIN0_LEVEL] ==
        $past(i_output_pin0_level, 2))
        else $error("pin bits do not follow pin levels");

    unused_zero_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        status_read_s |=> o_rd_data[1] == 1'b0)
        else $error("unused status bit read as one");

    tx_level_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        rd_take && i_rd_addr == radio_status_pkg::OFS_TRANSMIT_BUFFER_LEVEL
        |=> o_rd_data == $past({i_transmit_buffer_underrun,
                                 i_transmit_byte_count}))
        else $error("transmit level read mismatch");

    rx_level_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        rd_take && i_rd_addr == radio_status_pkg::OFS_RECEIVE_BUFFER_LEVEL
        |=> o_rd_data == $past({i_receive_buffer_overrun,
                                 i_receive_byte_count}))
        else $error("receive level read mismatch");

    dac_read_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        rd_take && i_rd_addr == radio_status_pkg::OFS_LOOP_CAL_DAC_READBACK
        |=> o_rd_data == $past(i_loop_cal_dac))
        else $error("calibration dac read mismatch");

    chan_clear_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        status_read_s ##0 $past(i_reset_n) |=>
        o_rd_data[radio_status_pkg::BIT_CHANNEL_CLEAR] ==
        $past(i_channel_clear_flag, 2))
        else $error("channel clear bit does not follow input");

    frame_end_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        i_packet_end && !frame_start_set |=> !frame_start_flag_r)
        else $error("frame start kept after packet end");

    carrier_follow_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        !in_idle |=> carrier_sense_r == $past(i_carrier_sense))
        else $error("carrier sense does not follow input");

    write_ignored_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        i_wr_en |=> !o_rd_valid && $stable(o_rd_data))
        else $error("write cycle changed the read port");

    osc_cal_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        i_osc_cal_done ##1 (rd_take && i_rd_addr ==
            radio_status_pkg::OFS_SLOW_OSC_CAL_RESULT_LOW && !i_osc_cal_done)
        |=> o_rd_data == {1'b0, $past(i_osc_cal_low, 2)})
        else $error("oscillator cal result not latched");

endmodule

/* verification/host_reader.sv */
// host model that reads the status registers over the read port
`timescale 1ns/1ns
module host_reader (
    input wire logic i_clk_sys, // system clock
    input wire logic i_rd_valid, // answer strobe
    input wire logic [7:0] i_rd_data, // answer data
    output logic o_rd_en, // read strobe
    output logic o_wr_en, // write strobe
    output logic [5:0] o_rd_addr // register address
);
    initial begin
        o_rd_en = 1'b0;
        o_wr_en = 1'b0;
        o_rd_addr = 6'h15;
    end

    // ********************************************************
    // bus cycles, entered 1 ns after a clock edge
    // ********************************************************
    // pin bits are read as plain levels, never polled for lock
    task automatic rd(input logic [5:0] a, input bit keep,
                      output logic v, output logic [7:0] d);
        o_rd_en = 1'b1;
        o_rd_addr = a;
        @(posedge i_clk_sys);
        #1;
        v = i_rd_valid;
        d = i_rd_data;
        if (!keep) begin
            o_rd_en = 1'b0;
            // released address does not keep its last value
            o_rd_addr = ~a;
        end
    endtask

    task automatic wr(input logic [5:0] a, output logic v);
        o_rd_en = 1'b1;
        o_wr_en = 1'b1;
        o_rd_addr = a;
        @(posedge i_clk_sys);
        #1;
        o_rd_en = 1'b0;
        o_wr_en = 1'b0;
        o_rd_addr = ~a;
        v = i_rd_valid;
    endtask
endmodule

/* verification/radio_status_readback_tb_top.sv */
// self-checking bench for the radio status readback registers
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module radio_status_readback_tb_top;
    typedef struct packed {
        logic [5:0] a;
        logic [7:0] val;
        logic [7:0] exp;
    } row_t;
    logic i_clk_sys = 1'b0;
    logic i_reset_n = 1'b0;
    logic [4:0] state = 5'h08;
    logic ck_done = 1'b0;
    logic ck_match = 1'b0;
    logic [7:0] preamble_quality_indicator = 8'h00;
    logic [7:0] preamble_quality_threshold = 8'h01;
    logic sync = 1'b0;
    logic pend = 1'b0;
    logic pdrop = 1'b0;
    logic cal_done = 1'b0;
    logic [7:0] src [6'h38:6'h3d] = '{default: 8'h00};
    logic rd_en, wr_en, rd_valid, v;
    logic [5:0] rd_addr;
    logic [7:0] rd_data, d;
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;
    row_t rows [14] = '{'{6'h38, 8'hff, 8'h55}, '{6'h38, 8'haa, 8'h00},
        '{6'h38, 8'h14, 8'h14}, '{6'h38, 8'h04, 8'h04},
        '{6'h38, 8'h01, 8'h01}, '{6'h39, 8'ha5, 8'ha5},
        '{6'h3a, 8'h80, 8'h80}, '{6'h3a, 8'h7f, 8'h7f},
        '{6'h3b, 8'hc1, 8'hc1}, '{6'h3b, 8'h3f, 8'h3f},
        '{6'h3c, 8'hff, 8'h7f}, '{6'h3d, 8'h2a, 8'h2a},
        '{6'h3e, 8'h12, 8'h00}, '{6'h37, 8'hff, 8'h00}};

    always #20 i_clk_sys = ~i_clk_sys;

    radio_status_readback uut (
        .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
        .i_rd_en(rd_en), .i_rd_addr(rd_addr), .i_wr_en(wr_en),
        .i_radio_control_state(state),
        .i_checksum_done(ck_done), .i_checksum_match(ck_match),
        .i_carrier_sense(src[6'h38][6]),
        .i_preamble_quality_indicator(preamble_quality_indicator),
        .i_preamble_quality_threshold(preamble_quality_threshold),
        .i_channel_clear_flag(src[6'h38][4]),
        .i_sync_found(sync), .i_packet_end(pend),
        .i_packet_dropped(pdrop),
        .i_output_pin2_level(src[6'h38][2]),
        .i_output_pin0_level(src[6'h38][0]),
        .i_loop_cal_dac(src[6'h39]),
        .i_transmit_buffer_underrun(src[6'h3a][7]),
        .i_transmit_byte_count(src[6'h3a][6:0]),
        .i_receive_buffer_overrun(src[6'h3b][7]),
        .i_receive_byte_count(src[6'h3b][6:0]),
        .i_osc_cal_done(cal_done), .i_osc_cal_high(src[6'h3c][6:0]),
        .i_osc_cal_low(src[6'h3d][6:0]),
        .o_rd_valid(rd_valid), .o_rd_data(rd_data)
    );

    host_reader host (
        .i_clk_sys(i_clk_sys), .i_rd_valid(rd_valid),
        .i_rd_data(rd_data), .o_rd_en(rd_en), .o_wr_en(wr_en),
        .o_rd_addr(rd_addr)
    );

    // ********************************************************
    // helpers
    // ********************************************************
    task automatic tick();
        @(posedge i_clk_sys);
        #1;
    endtask

    task automatic chk38(input logic [7:0] e);
        tick();
        host.rd(6'h38, 1'b0, v, d);
        `CHK(d, e);
    endtask

    task automatic close_out();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // hang guard, well above the roughly 110 cycles needed
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            n_fail++;
            $display("MISMATCH t=%0t timeout", $time);
            close_out();
        end
    end

    // ********************************************************
    // tests
    // ********************************************************
    initial begin
        repeat (2) @(posedge i_clk_sys);
        #1;
        `CHK(rd_valid, 1'b0);
        `CHK(rd_data, 8'h00);
        i_reset_n = 1'b1;
        $display("reset test done");
        foreach (rows[i]) begin
            if (rows[i].a inside {[6'h38:6'h3d]}) begin
                src[rows[i].a] = rows[i].val;
            end
            cal_done = 1'b1;
            tick();
            cal_done = 1'b0;
            tick();
            host.rd(rows[i].a, 1'b0, v, d);
            `CHK(v, 1'b1);
            `CHK(d, rows[i].exp);
        end
        $display("table test done");
        host.rd(6'h3a, 1'b1, v, d);
        `CHK(d, src[6'h3a]);
        host.rd(6'h3b, 1'b0, v, d);
        `CHK(d, src[6'h3b]);
        tick();
        `CHK(rd_valid, 1'b0);
        host.wr(6'h3a, v);
        `CHK(v, 1'b0);
        tick();
        host.rd(6'h3a, 1'b0, v, d);
        `CHK(d, src[6'h3a]);
        $display("back to back and write test done");
        src[6'h38] = 8'h00;
        state = 5'h0d;
        tick();
        ck_match = 1'b1;
        ck_done = 1'b1;
        tick();
        ck_done = 1'b0;
        chk38(8'h80);
        state = 5'h0f;
        chk38(8'h00);
        state = 5'h0d;
        ck_done = 1'b1;
        tick();
        ck_done = 1'b0;
        ck_match = 1'b0;
        chk38(8'h80);
        ck_done = 1'b1;
        tick();
        ck_done = 1'b0;
        chk38(8'h00);
        src[6'h38] = 8'h40;
        chk38(8'h40);
        state = 5'h01;
        chk38(8'h00);
        src[6'h38] = 8'h00;
        state = 5'h0d;
        preamble_quality_indicator = 8'h05;
        preamble_quality_threshold = 8'h05;
        chk38(8'h20);
        state = 5'h08;
        chk38(8'h20);
        preamble_quality_indicator = 8'h04;
        chk38(8'h00);
        preamble_quality_indicator = 8'h05;
        chk38(8'h00);
        preamble_quality_indicator = 8'h00;
        $display("status flag test done");
        for (int k = 0; k < 5; k++) begin
            state = (k == 1) ? 5'h0e : 5'h0d;
            sync = 1'b1;
            tick();
            sync = 1'b0;
            chk38(8'h08);
            pend = (k == 0);
            pdrop = (k == 1);
            if (k == 2) begin
                state = 5'h11;
            end
            if (k > 2) begin
                state = (k == 3) ? 5'h13 : 5'h14;
            end
            tick();
            pend = 1'b0;
            pdrop = 1'b0;
            chk38(8'h00);
        end
        $display("frame start test done");
        src[6'h39] = 8'hc3;
        tick();
        host.rd(6'h39, 1'b0, v, d);
        `CHK(d, 8'hc3);
        i_reset_n = 1'b0;
        #5;
        `CHK(rd_valid, 1'b0);
        `CHK(rd_data, 8'h00);
        tick();
        i_reset_n = 1'b1;
        host.rd(6'h3c, 1'b0, v, d);
        `CHK(d, 8'h00);
        $display("second reset test done");
        close_out();
    end
endmodule
